/* File: verilog/size_select_pkg.sv */
// Shared constants and carrier types for operand and address size selection.
package size_select_pkg;

    // ==================================================================
    // Prefix bytes
    localparam logic [7:0] OP_SIZE_PREFIX = 8'h66;
    localparam logic [7:0] ADDR_SIZE_PREFIX = 8'h67;

    // ==================================================================
    // Processor modes
    localparam logic [1:0] MODE_REAL = 2'h0;
    localparam logic [1:0] MODE_PROT = 2'h1;
    localparam logic [1:0] MODE_V86 = 2'h2;
    localparam logic [1:0] MODE_SYS_MGMT = 2'h3;

    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LIMIT = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;

    // ==================================================================
    // Control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CS_BIG_BIT = 2;
    localparam int CTRL_SS_BIG_BIT = 3;
    localparam int CTRL_DATA_BIG_BIT = 4;
    localparam int CTRL_CLR_BIT = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // ==================================================================
    // Status register fields
    localparam int STAT_OP32_BIT = 0;
    localparam int STAT_ADDR32_BIT = 1;
    localparam int STAT_STACK32_BIT = 2;
    localparam int STAT_NATIVE16_BIT = 3;
    localparam int STAT_FRAME32_BIT = 4;
    localparam int STAT_XSTACK32_BIT = 5;
    localparam int STAT_GATE_BIT = 6;

    // ==================================================================
    // Expand-down upper bounds and count layout
    localparam logic [31:0] LIMIT_BIG = 32'hffffffff;
    localparam logic [31:0] LIMIT_SMALL = 32'h0000ffff;
    localparam int COUNT_ADDR_LSB = 16;
    localparam int COUNT_MAX_W = 16;

    // ==================================================================
    // Carrier types
    typedef struct packed {
        logic valid;
        logic opcode;
        logic [7:0] data;
    } fetch_byte_t;

    typedef struct packed {
        logic valid;
        logic is_32;
    } gate_req_t;

    typedef struct packed {
        logic valid;
        logic gate;
        logic op32;
        logic addr32;
        logic stack32;
        logic xstack32;
        logic frame32;
    } size_result_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

endpackage

/* File: verilog/size_choice.sv */
// One size decision: segment default, prefix inversion, or gate type.
`timescale 1ns/1ps
module size_choice (
    input wire logic default_big,
    input wire logic prefix_seen,
    input wire logic gate_used,
    input wire logic gate_big,
    output logic big
);

    // ==================================================================
    // Decision
    always_comb begin
        if (gate_used) begin
            big = gate_big;
        end else begin
            big = default_big ^ prefix_seen;
        end
    end

endmodule

/* File: verilog/operand_address_size_select.sv */
// Decode-stage selection of operand, address and stack sizes with a register port.
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module operand_address_size_select
    import size_select_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire fetch_byte_t fetch,
    input wire gate_req_t gate,
    input wire wb_req_t wb_req,
    output wb_rsp_t wb_rsp,
    output size_result_t result,
    output logic stack_wide,
    output logic [31:0] expand_down_limit
);

    // ==================================================================
    // Parameter check
    if (CNT_W < 1 || CNT_W > COUNT_MAX_W) begin : g_bad_cnt
        $error("CNT_W must lie between 1 and 16");
    end

    // ==================================================================
    // State
    typedef enum logic [0:0] {
        DEC_IDLE,
        DEC_PREFIX
    } dec_state_t;

    typedef struct packed {
        dec_state_t st;
        logic op_pfx;
        logic adr_pfx;
        logic [CTRL_W-1:0] ctrl;
        size_result_t res;
        logic stack_wide;
        logic [31:0] limit;
        logic [CNT_W-1:0] op_cnt;
        logic [CNT_W-1:0] adr_cnt;
        logic ack;
        logic [31:0] rdat;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ==================================================================
    // Configuration decode
    logic [1:0] mode;
    logic native16;
    logic seg_big;
    logic stk_big;
    logic op_big;
    logic adr_big;
    logic is_op_pfx;
    logic is_adr_pfx;
    logic pfx_byte;
    logic op_byte;
    logic op_pfx_eff;
    logic adr_pfx_eff;
    logic bus_req;
    logic bus_write;
    logic clr_req;
    logic [31:0] ctrl_word;
    logic [31:0] wr_word;
    logic [31:0] status_word;
    logic [31:0] count_word;

    assign mode = s_r.ctrl[CTRL_MODE_LSB +: 2];

    assign native16 = (mode == MODE_REAL) || (mode == MODE_V86) || (mode == MODE_SYS_MGMT);

    assign seg_big = !native16 && s_r.ctrl[CTRL_CS_BIG_BIT];

    assign stk_big = !native16 && s_r.ctrl[CTRL_SS_BIG_BIT];

    // ==================================================================
    // Prefix scanning
    assign pfx_byte = fetch.valid && !fetch.opcode;
    assign op_byte = fetch.valid && fetch.opcode;

    assign is_op_pfx = pfx_byte && (fetch.data == OP_SIZE_PREFIX);
    assign is_adr_pfx = pfx_byte && (fetch.data == ADDR_SIZE_PREFIX);

    // Prefixes seen so far for the instruction now ending.
    assign op_pfx_eff = s_r.op_pfx;
    assign adr_pfx_eff = s_r.adr_pfx;

    size_choice u_op_size (
        .default_big(seg_big),
        .prefix_seen(op_pfx_eff),
        .gate_used(gate.valid),
        .gate_big(gate.is_32),
        .big(op_big)
    );

    // Address size never comes from a gate.
    size_choice u_adr_size (
        .default_big(seg_big),
        .prefix_seen(adr_pfx_eff),
        .gate_used(1'b0),
        .gate_big(1'b0),
        .big(adr_big)
    );

    // ==================================================================
    // Register bus decode
    assign bus_req = wb_req.cyc && wb_req.stb;

    // The write lands on the edge where the master sees ack.
    assign bus_write = bus_req && wb_req.we && s_r.ack && (wb_req.adr == REG_CTRL);

    assign clr_req = bus_write && wb_req.sel[CTRL_CLR_BIT / 8] && wb_req.dat[CTRL_CLR_BIT];

    always_comb begin
        ctrl_word = 32'h00000000;
        ctrl_word[CTRL_W-1:0] = s_r.ctrl;
    end

    always_comb begin
        wr_word = ctrl_word;
        for (int i = 0; i < 4; i++) begin
            if (wb_req.sel[i]) begin
                wr_word[i*8 +: 8] = wb_req.dat[i*8 +: 8];
            end
        end
    end

    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_OP32_BIT] = s_r.res.op32;
        status_word[STAT_ADDR32_BIT] = s_r.res.addr32;
        status_word[STAT_STACK32_BIT] = s_r.res.stack32;
        status_word[STAT_NATIVE16_BIT] = native16;
        status_word[STAT_FRAME32_BIT] = s_r.res.frame32;
        status_word[STAT_XSTACK32_BIT] = s_r.res.xstack32;
        status_word[STAT_GATE_BIT] = s_r.res.gate;
    end

    always_comb begin
        count_word = 32'h00000000;
        count_word[CNT_W-1:0] = s_r.op_cnt;
        count_word[COUNT_ADDR_LSB +: CNT_W] = s_r.adr_cnt;
    end

    // ==================================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.res.valid = 1'b0;

        if (is_op_pfx) begin
            s_nxt.op_pfx = 1'b1;
        end
        if (is_adr_pfx) begin
            s_nxt.adr_pfx = 1'b1;
        end

        case (s_r.st)
            DEC_IDLE: begin
                if (pfx_byte) begin
                    s_nxt.st = DEC_PREFIX;
                end
            end
            DEC_PREFIX: begin
                if (op_byte) begin
                    s_nxt.st = DEC_IDLE;
                end
            end
            default: begin
                s_nxt.st = DEC_IDLE;
            end
        endcase

        if (op_byte || gate.valid) begin
            s_nxt.res.valid = 1'b1;
            s_nxt.res.gate = gate.valid;
            s_nxt.res.op32 = op_big;
            s_nxt.res.addr32 = adr_big;
            s_nxt.res.stack32 = stk_big;
            s_nxt.res.xstack32 = adr_big;
            s_nxt.res.frame32 = op_big;
        end

        if (op_byte) begin
            s_nxt.op_pfx = 1'b0;
            s_nxt.adr_pfx = 1'b0;
        end

        // Clearing the counts loses no event: a same-cycle increment still counts.
        if (clr_req) begin
            s_nxt.op_cnt = '0;
            s_nxt.adr_cnt = '0;
        end
        if (op_byte && s_r.op_pfx) begin
            s_nxt.op_cnt = clr_req ? CNT_W'(1) : s_r.op_cnt + CNT_W'(1);
        end
        if (op_byte && s_r.adr_pfx) begin
            s_nxt.adr_cnt = clr_req ? CNT_W'(1) : s_r.adr_cnt + CNT_W'(1);
        end

        s_nxt.stack_wide = stk_big;

        s_nxt.limit = s_r.ctrl[CTRL_DATA_BIG_BIT] ? LIMIT_BIG : LIMIT_SMALL;

        if (bus_write) begin
            s_nxt.ctrl = wr_word[CTRL_W-1:0];
        end

        // One wait state, then ack for a single cycle.
        s_nxt.ack = bus_req && !s_r.ack;
        if (bus_req && !s_r.ack) begin
            case (wb_req.adr)
                REG_CTRL: begin
                    s_nxt.rdat = ctrl_word;
                end
                REG_STATUS: begin
                    s_nxt.rdat = status_word;
                end
                REG_LIMIT: begin
                    s_nxt.rdat = s_r.limit;
                end
                REG_COUNT: begin
                    s_nxt.rdat = count_word;
                end
                default: begin
                    s_nxt.rdat = 32'h00000000;
                end
            endcase
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.st <= DEC_IDLE;
            s_r.op_pfx <= 1'b0;
            s_r.adr_pfx <= 1'b0;
            s_r.ctrl <= CTRL_RESET;
            s_r.res <= '0;
            s_r.stack_wide <= 1'b0;
            s_r.limit <= LIMIT_SMALL;
            s_r.op_cnt <= '0;
            s_r.adr_cnt <= '0;
            s_r.ack <= 1'b0;
            s_r.rdat <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================================
    // Outputs
    assign wb_rsp.ack = s_r.ack;
    assign wb_rsp.dat = s_r.rdat;
    assign result = s_r.res;
    assign stack_wide = s_r.stack_wide;
    assign expand_down_limit = s_r.limit;

endmodule

/* File: dv/size_select_props.sv */
// Checker for the size selection block, seeing its ports only.
`timescale 1ns/1ps
module size_select_props
    import size_select_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire fetch_byte_t fetch,
    input wire gate_req_t gate,
    input wire wb_req_t wb_req,
    input wire wb_rsp_t wb_rsp,
    input wire size_result_t result,
    input wire logic stack_wide,
    input wire logic [31:0] expand_down_limit
);
    // ==================================================================
    // Shadow state
    // The shadow copies the control write at the acked edge, as the block does.
    typedef struct packed {
        logic [4:0] ctl;
        logic p66;
        logic p67;
        logic eop;
        logic ead;
    } shadow_t;
    shadow_t sh_r;
    shadow_t sh_nxt;
    logic big;
    assign big = (sh_r.ctl[1:0] == MODE_PROT) && sh_r.ctl[CTRL_CS_BIG_BIT];
    always_comb begin
        sh_nxt = sh_r;
        if (wb_rsp.ack && wb_req.cyc && wb_req.stb && wb_req.we && wb_req.adr == REG_CTRL
            && wb_req.sel[0]) begin
            sh_nxt.ctl = wb_req.dat[4:0];
        end
        if (fetch.valid && !fetch.opcode && fetch.data == OP_SIZE_PREFIX) begin
            sh_nxt.p66 = 1'b1;
        end
        if (fetch.valid && !fetch.opcode && fetch.data == ADDR_SIZE_PREFIX) begin
            sh_nxt.p67 = 1'b1;
        end
        sh_nxt.eop = gate.valid ? gate.is_32 : big ^ sh_r.p66;
        sh_nxt.ead = big ^ sh_r.p67;
        if (fetch.valid && fetch.opcode) begin
            sh_nxt.p66 = 1'b0;
            sh_nxt.p67 = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_single_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack stood longer than one cycle");
    a_ack_next_cycle: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("ack did not follow the request");
    a_opcode_gives_result: assert property (fetch.valid && fetch.opcode |=> result.valid)
        else $error("no result after an opcode byte");
    a_gate_sets_size: assert property (gate.valid |=> result.valid && result.gate
        && result.op32 == $past(gate.is_32)) else $error("gate size not applied");
    a_frame_follows_op: assert property (result.valid |-> result.frame32 == result.op32)
        else $error("frame size differs from operand size");
    a_operand_size: assert property (result.valid |-> result.op32 == sh_r.eop)
        else $error("operand size wrong");
    a_address_size: assert property (result.valid |-> result.addr32 == sh_r.ead)
        else $error("address size wrong");
    a_explicit_stack_addr: assert property (result.valid |-> result.xstack32 == result.addr32)
        else $error("explicit stack size differs from address size");
    a_stack_ptr_width: assert property (stack_wide ==
        $past(sh_r.ctl[1:0] == MODE_PROT && sh_r.ctl[CTRL_SS_BIG_BIT]))
        else $error("stack pointer width wrong");
    a_expand_down_bound: assert property (expand_down_limit ==
        ($past(sh_r.ctl[CTRL_DATA_BIG_BIT]) ? LIMIT_BIG : LIMIT_SMALL))
        else $error("expand-down bound wrong");
    c_gate_with_opcode: cover property (gate.valid && fetch.valid && fetch.opcode);
    c_both_small: cover property (result.valid && !result.op32 && !result.addr32);
    c_bus_write: cover property (wb_rsp.ack && wb_req.we);
endmodule

bind operand_address_size_select size_select_props #(.CNT_W(CNT_W)) u_props (.clk(clk),
    .rst(rst), .fetch(fetch), .gate(gate), .wb_req(wb_req), .wb_rsp(wb_rsp), .result(result),
    .stack_wide(stack_wide), .expand_down_limit(expand_down_limit));

/* File: dv/tb_top.sv */
// Self-checking bench for operand, address and stack size selection.
`timescale 1ns/1ps
module tb_top
    import size_select_pkg::*;
;
    // ==================================================================
    // Stimulus rows and signals
    typedef struct packed {
        logic [1:0] md;
        logic cs, ss, df, p66, p67, op, ad, sw;
    } row_t;
    localparam int NR = 12;
    // protected rows keep code and stack flags paired, except the last.
    row_t rows [NR] = '{
        '{MODE_PROT, 1, 1, 0, 0, 0, 1, 1, 1}, '{MODE_PROT, 1, 1, 0, 1, 0, 0, 1, 1},
        '{MODE_PROT, 1, 1, 0, 0, 1, 1, 0, 1}, '{MODE_PROT, 1, 1, 0, 1, 1, 0, 0, 1},
        '{MODE_PROT, 0, 0, 0, 0, 0, 0, 0, 0}, '{MODE_PROT, 0, 0, 0, 1, 0, 1, 0, 0},
        '{MODE_PROT, 0, 0, 0, 0, 1, 0, 1, 0}, '{MODE_PROT, 0, 0, 0, 1, 1, 1, 1, 0},
        '{MODE_REAL, 1, 1, 0, 0, 0, 0, 0, 0}, '{MODE_V86, 1, 1, 0, 1, 0, 1, 0, 0},
        '{MODE_SYS_MGMT, 1, 1, 1, 1, 1, 1, 1, 0}, '{MODE_PROT, 0, 1, 1, 0, 0, 0, 0, 1}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    fetch_byte_t fetch = '0;
    gate_req_t gate = '0;
    wb_req_t wb_req = '0;
    wb_rsp_t wb_rsp;
    size_result_t result;
    logic stack_wide;
    logic [31:0] expand_down_limit;
    logic [31:0] rd;
    int errors = 0;
    int compares = 0;

    always #50 clk = ~clk;

    operand_address_size_select #(.CNT_W(16)) dut (.clk(clk), .rst(rst), .fetch(fetch),
        .gate(gate), .wb_req(wb_req), .wb_rsp(wb_rsp), .result(result), .stack_wide(stack_wide),
        .expand_down_limit(expand_down_limit));

    // ==================================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The master waits for ack itself; only the watchdog bounds a lost answer.
    // Ack is looked at once settled, and the request is held through the edge that sees it.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, d};
        @(posedge clk);
        #1;
        while (wb_rsp.ack !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        rd = wb_rsp.dat;
        @(posedge clk);
        wb_req <= '0;
    endtask

    task automatic step(input logic v, op, input logic [7:0] b, input logic gv, g32);
        @(posedge clk);
        fetch <= '{v, op, b};
        gate <= '{gv, g32};
        @(posedge clk);
        fetch <= '0;
        gate <= '0;
        #1;
    endtask

    task automatic expect_res(input logic op, ad, g);
        check("valid", result.valid, 1);
        check("op32", result.op32, op);
        check("addr32", result.addr32, ad);
        check("gate", result.gate, g);
        check("frame32", result.frame32, op);
        check("xstack32", result.xstack32, ad);
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("rst_limit", expand_down_limit, LIMIT_SMALL);
        check("rst_stack", stack_wide, 0);
        $display("test reset done");
        for (int i = 0; i < NR; i++) begin
            wb(1, REG_CTRL, {27'h0, rows[i].df, rows[i].ss, rows[i].cs, rows[i].md});
            if (rows[i].p66) step(1, 0, OP_SIZE_PREFIX, 0, 0);
            if (rows[i].p67) step(1, 0, ADDR_SIZE_PREFIX, 0, 0);
            step(1, 1, 8'h8b, 0, 0);
            expect_res(rows[i].op, rows[i].ad, 0);
            check("stack_wide", stack_wide, rows[i].sw);
            check("limit", expand_down_limit, rows[i].df ? LIMIT_BIG : LIMIT_SMALL);
        end
        $display("test table done");
        wb(1, REG_CTRL, 32'h0000000d);
        repeat (3) step(1, 0, OP_SIZE_PREFIX, 0, 0);
        step(1, 1, 8'h8b, 0, 0);
        expect_res(0, 1, 0);
        step(1, 1, 8'h8b, 0, 0);
        expect_res(1, 1, 0);
        $display("test repeat done");
        step(1, 0, ADDR_SIZE_PREFIX, 0, 0);
        step(1, 0, OP_SIZE_PREFIX, 0, 0);
        step(0, 0, 8'h00, 1, 0);
        expect_res(0, 0, 1);
        step(1, 1, 8'h8b, 1, 1);
        expect_res(1, 0, 1);
        step(1, 1, 8'h8b, 0, 0);
        expect_res(1, 1, 0);
        $display("test gate done");
        wb(0, REG_CTRL, 0);
        check("ctrl", rd, 32'h0000000d);
        wb(0, REG_STATUS, 0);
        check("status_op", rd[STAT_OP32_BIT], 1);
        check("status_native", rd[STAT_NATIVE16_BIT], 0);
        wb(0, 8'h10, 0);
        check("unmapped", rd, 0);
        wb(1, REG_LIMIT, 32'h00000001);
        wb(0, REG_LIMIT, 0);
        check("limit_ro", rd, LIMIT_SMALL);
        wb(1, REG_CTRL, 32'h0000010d);
        wb(0, REG_COUNT, 0);
        check("count_clear", rd, 0);
        step(1, 0, OP_SIZE_PREFIX, 0, 0);
        step(1, 1, 8'h8b, 0, 0);
        expect_res(0, 1, 0);
        wb(0, REG_COUNT, 0);
        check("count_op", rd, 32'h00000001);
        wb(0, REG_CTRL, 0);
        check("ctrl_kept", rd, 32'h0000000d);
        $display("test registers done");
        print_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk);
        check("watchdog", 32'h1, 32'h0);
        print_verdict();
    end
endmodule
